// [rtl/fsp_regs.svh]
// fsp_regs.svh: encodings, levels and reset values of the fault signal protocol block
// assumes inclusion by the fsp package and the design modules only
`ifndef FSP_REGS_SVH
`define FSP_REGS_SVH

`define FSP_MODE_BISTABLE  2'h0
`define FSP_MODE_TIMESW    2'h2
`define FSP_MODE_DUALRAIL  2'h1

`define FSP_LVL_FREE       2'h1
`define FSP_LVL_FAULT      2'h0
`define FSP_LVL_DUAL_INIT  2'h1
`define FSP_BIT0_MASK      2'h1
`define FSP_BOTH_MASK      2'h3

`define FSP_ALM_NONE       2'h0
`define FSP_RT_NONE        2'h0
`define FSP_RT_IDX0        0
`define FSP_RT_IDX1        1

`endif

// [rtl/fsp_pkg.sv]
// fsp_pkg: types shared by the fault signal protocol block
// assumes fsp_regs.svh on the include path
`include "fsp_regs.svh"

package fsp_pkg;

  typedef enum logic [1:0] {
    FSP_BISTABLE = 2'b00,
    FSP_TIMESW   = 2'b10,
    FSP_DUALRAIL = 2'b01,
    FSP_RSVD     = 2'b11
  } fsp_mode_t;

  typedef enum logic {
    FSP_ST_FREE  = 1'b0,
    FSP_ST_FAULT = 1'b1
  } fsp_state_t;

endpackage

// [rtl/fsp_presc.sv]
// fsp_presc: free counter that pulses once every div_i+1 cycles while run_i is high
// assumes div_i is steady while running; a change takes effect at once, as cnt_q is compared with the live div_i
`timescale 1ns/10ps

module fsp_presc #(
  parameter int W = 8
) (
  // clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  // control
  input  wire logic         run_i,
  input  wire logic [W-1:0] div_i,
  // tick
  output logic              tick_o
);

  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;
  logic         tick_q;
  logic         tick_d;

  always_comb begin
    cnt_d  = cnt_q;
    tick_d = 1'b0;
    if (!run_i) begin
      cnt_d = '0;
    end else if (cnt_q >= div_i) begin
      cnt_d  = '0;
      tick_d = 1'b1;
    end else begin
      cnt_d = cnt_q + W'(1);
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      cnt_q  <= '0;
      tick_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      tick_q <= tick_d;
    end
  end

  assign tick_o = tick_q;

endmodule

// [rtl/fsp_ctrl.sv]
// fsp_ctrl: fault signal pair driver with protocol modes, fault-state and recovery timers
// assumes all inputs come from logic on clk_i; por_n_i is the power-on reset, rst_n_i any reset
`timescale 1ns/10ps
`include "fsp_regs.svh"

module fsp_ctrl
  import fsp_pkg::*;
#(
  parameter int PRE_W  = 8,
  parameter int TIME_W = 16
) (
  // clock and resets
  input  wire logic              clk_i,
  input  wire logic              rst_n_i,
  input  wire logic              por_n_i,
  // configuration writes
  input  wire logic              mode_we_i,
  input  wire logic [1:0]        mode_i,
  input  wire logic              toggle_prescaler_we_i,
  input  wire logic [PRE_W-1:0]  toggle_prescaler_i,
  input  wire logic              fault_state_prescaler_we_i,
  input  wire logic [PRE_W-1:0]  fault_state_prescaler_i,
  input  wire logic              min_fault_state_time_we_i,
  input  wire logic [TIME_W-1:0] min_fault_state_time_i,
  input  wire logic              recovery_timer_duration_we_i,
  input  wire logic [TIME_W-1:0] recovery_timer_duration_i,
  // fault events
  input  wire logic              fault_enter_i,
  input  wire logic              fault_release_i,
  input  wire logic [1:0]        recovery_start_i,
  input  wire logic [1:0]        recovery_stop_i,
  // fault signal pins
  output logic [1:0]             fault_signal_o,
  // status
  output logic [1:0]             mode_o,
  output logic                   fault_state_o,
  output logic                   fault_state_timer_done_o,
  output logic                   recovery_timer0_running_o,
  output logic                   recovery_timer1_running_o,
  // alarms
  output logic                   alarm_sync_o,
  output logic [1:0]             alarm_recovery_o
);

  fsp_mode_t         mode_q, mode_d;
  fsp_state_t        st_q, st_d;
  logic [PRE_W-1:0]  tpre_q, tpre_d, fpre_q, fpre_d;
  logic [TIME_W-1:0] tmin_q, tmin_d, rtd_q, rtd_d;
  logic [TIME_W-1:0] fs_cnt_q, fs_cnt_d;
  logic              done_q, done_d;
  logic [1:0]        fsp_q, fsp_d;
  logic [1:0]        rt_run_q, rt_run_d;
  logic [TIME_W-1:0] rt_cnt_q [2];
  logic [TIME_W-1:0] rt_cnt_d [2];
  logic              alm_sync_q, alm_sync_d;
  logic [1:0]        alm_rt_q, alm_rt_d;
  logic              tog_run, tog_tick, fs_run, fs_tick;

  function automatic logic [TIME_W-1:0] sat_inc(input logic [TIME_W-1:0] v);
    sat_inc = (v == {TIME_W{1'b1}}) ? v : v + TIME_W'(1);
  endfunction

  // toggling happens only in fault-free state with a toggling mode
  // the reserved code never toggles and keeps the last level, except that a late toggle tick sets the free level; a prescaler write there is no hazard
  assign tog_run = (st_q == FSP_ST_FREE) && ((mode_q == FSP_TIMESW) || (mode_q == FSP_DUALRAIL));
  assign fs_run  = (st_q == FSP_ST_FAULT) || (rt_run_q != `FSP_RT_NONE);

  fsp_presc #(.W(PRE_W)) u_tog_presc (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .run_i   (tog_run),
    .div_i   (tpre_q),
    .tick_o  (tog_tick)
  );

  fsp_presc #(.W(PRE_W)) u_fs_presc (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .run_i   (fs_run),
    .div_i   (fpre_q),
    .tick_o  (fs_tick)
  );

  // configuration and protocol state
  always_comb begin
    mode_d = mode_we_i ? fsp_mode_t'(mode_i) : mode_q;
    tpre_d = toggle_prescaler_we_i ? toggle_prescaler_i : tpre_q;
    fpre_d = fault_state_prescaler_we_i ? fault_state_prescaler_i : fpre_q;
    tmin_d = min_fault_state_time_we_i ? min_fault_state_time_i : tmin_q;
    rtd_d  = recovery_timer_duration_we_i ? recovery_timer_duration_i : rtd_q;
    st_d   = st_q;
    if (st_q == FSP_ST_FREE && fault_enter_i) begin
      st_d = FSP_ST_FAULT;
    end else if (st_q == FSP_ST_FAULT && fault_release_i && done_q) begin
      st_d = FSP_ST_FREE;
    end
    fs_cnt_d = '0;
    if (st_q == FSP_ST_FAULT && st_d == FSP_ST_FAULT) begin
      fs_cnt_d = fs_tick ? sat_inc(fs_cnt_q) : fs_cnt_q;
    end
    // done follows the live minimum, so a rewrite mid-fault is honoured at once
    done_d = (st_d == FSP_ST_FAULT) && (fs_cnt_d >= tmin_d);
    fsp_d = fsp_q;
    if (st_d == FSP_ST_FAULT) begin
      fsp_d = `FSP_LVL_FAULT;
    end else if (mode_q == FSP_BISTABLE || st_q == FSP_ST_FAULT) begin
      fsp_d = (mode_q == FSP_DUALRAIL) ? `FSP_LVL_DUAL_INIT : `FSP_LVL_FREE;
    end else if (tog_tick) begin
      case (mode_q)
        FSP_TIMESW:   fsp_d = fsp_q ^ `FSP_BIT0_MASK;
        FSP_DUALRAIL: fsp_d = fsp_q ^ `FSP_BOTH_MASK;
        default:      fsp_d = `FSP_LVL_FREE;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      mode_q   <= FSP_BISTABLE;
      st_q     <= FSP_ST_FREE;
      tpre_q   <= '0;
      fpre_q   <= '0;
      tmin_q   <= '0;
      rtd_q    <= '0;
      fs_cnt_q <= '0;
      done_q   <= 1'b0;
      fsp_q    <= `FSP_LVL_FREE;
    end else begin
      mode_q   <= mode_d;
      st_q     <= st_d;
      tpre_q   <= tpre_d;
      fpre_q   <= fpre_d;
      tmin_q   <= tmin_d;
      rtd_q    <= rtd_d;
      fs_cnt_q <= fs_cnt_d;
      done_q   <= done_d;
      fsp_q    <= fsp_d;
    end
  end

  // recovery timers count fault-state prescaler ticks up to the duration
  always_comb begin
    for (int k = 0; k < 2; k++) begin
      rt_run_d[k] = rt_run_q[k];
      rt_cnt_d[k] = rt_cnt_q[k];
      if (recovery_start_i[k]) begin
        rt_run_d[k] = 1'b1;
        rt_cnt_d[k] = '0;
      end else if (recovery_stop_i[k]) begin
        rt_run_d[k] = 1'b0;
      end else if (rt_run_q[k] && fs_tick) begin
        rt_cnt_d[k] = sat_inc(rt_cnt_q[k]);
        rt_run_d[k] = (sat_inc(rt_cnt_q[k]) < rtd_q);
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rt_run_q <= `FSP_RT_NONE;
      rt_cnt_q <= '{default: '0};
    end else begin
      rt_run_q <= rt_run_d;
      rt_cnt_q <= rt_cnt_d;
    end
  end

  // configuration hazard alarms; ordinary resets leave them alone, only power-on clears
  always_comb begin
    alm_sync_d = alm_sync_q;
    alm_rt_d   = alm_rt_q;
    if (toggle_prescaler_we_i && tog_run) begin
      alm_sync_d = 1'b1;
    end
    if ((fault_state_prescaler_we_i || min_fault_state_time_we_i) && st_q == FSP_ST_FAULT && !done_q) begin
      alm_sync_d = 1'b1;
    end
    if (fault_state_prescaler_we_i || recovery_timer_duration_we_i) begin
      alm_rt_d = alm_rt_q | rt_run_q;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!por_n_i) begin
      alm_sync_q <= 1'b0;
      alm_rt_q   <= `FSP_ALM_NONE;
    end else begin
      alm_sync_q <= alm_sync_d;
      alm_rt_q   <= alm_rt_d;
    end
  end

  assign fault_signal_o            = fsp_q;
  assign mode_o                    = mode_q;
  assign fault_state_o             = st_q;
  assign fault_state_timer_done_o  = done_q;
  assign recovery_timer0_running_o = rt_run_q[`FSP_RT_IDX0];
  assign recovery_timer1_running_o = rt_run_q[`FSP_RT_IDX1];
  assign alarm_sync_o              = alm_sync_q;
  assign alarm_recovery_o          = alm_rt_q;

  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  property p_bistable_level;
    (mode_q == FSP_BISTABLE) && (st_q == FSP_ST_FREE) && !fault_enter_i |=> fault_signal_o == `FSP_LVL_FREE;
  endproperty
  a_bistable_level: assert property (p_bistable_level) else $error("bistable level wrong");

  property p_toggle;
    tog_tick && tog_run && !fault_enter_i |=>
      (fault_signal_o ^ $past(fault_signal_o)) == (($past(mode_q) == FSP_DUALRAIL) ? `FSP_BOTH_MASK : `FSP_BIT0_MASK);
  endproperty
  a_toggle: assert property (p_toggle) else $error("fault signal did not toggle");

  property p_done_low;
    (st_q == FSP_ST_FAULT) && (fs_cnt_q < tmin_q) |-> !fault_state_timer_done_o;
  endproperty
  a_done_low: assert property (p_done_low) else $error("timer done before minimum");

  property p_rt_start;
    recovery_start_i[0] |=> recovery_timer0_running_o ##0 (rt_cnt_q[0] == '0);
  endproperty
  a_rt_start: assert property (p_rt_start) else $error("recovery timer 0 not running");

  property p_alm_toggle;
    toggle_prescaler_we_i && ((mode_q == FSP_TIMESW) || (mode_q == FSP_DUALRAIL)) && (st_q == FSP_ST_FREE)
      |=> alarm_sync_o;
  endproperty
  a_alm_toggle: assert property (p_alm_toggle) else $error("toggle write alarm missing");

  property p_alm_fault;
    min_fault_state_time_we_i && (st_q == FSP_ST_FAULT) && !fault_state_timer_done_o |=> alarm_sync_o;
  endproperty
  a_alm_fault: assert property (p_alm_fault) else $error("fault-state write alarm missing");

  property p_alm_rt;
    recovery_timer_duration_we_i && recovery_timer1_running_o |=> alarm_recovery_o[1];
  endproperty
  a_alm_rt: assert property (p_alm_rt) else $error("recovery write alarm missing");

  property p_alm_sticky;
    @(posedge clk_i) disable iff (!por_n_i) alarm_sync_o |=> alarm_sync_o [*2];
  endproperty
  a_alm_sticky: assert property (p_alm_sticky) else $error("alarm cleared without power-on");

endmodule

// [bench/fsp_mon.sv]
// fsp_mon: safety monitor model that watches the fault signal pin pair
// assumes pins are registered on clk_i; reports the spacing of pin 0 edges
`timescale 1ns/10ps

module fsp_mon (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  // observed pins
  input  wire logic [1:0] pins_i,
  // findings
  output logic [7:0]      period_o,
  output logic            both_o
);
  logic [1:0] last_q;
  logic [7:0] cnt_q;

  // a real monitor sees only edges, so the period runs edge to edge
  always_ff @(posedge clk_i) begin
    last_q <= pins_i;
    if (!rst_n_i) begin
      cnt_q    <= 8'h00;
      period_o <= 8'h00;
      both_o   <= 1'b0;
    end else if (pins_i[0] != last_q[0]) begin
      period_o <= cnt_q;
      both_o   <= (pins_i[1] != last_q[1]);
      cnt_q    <= 8'h01;
    end else begin
      cnt_q <= cnt_q + 8'h01;
    end
  end
endmodule

// [bench/fault_signal_protocol_ctrl_bench.sv]
// fault_signal_protocol_ctrl_bench: self-checking bench for fsp_ctrl
// assumes default widths; expectations go to a queue, a watcher compares at negedge
`timescale 1ns/10ps

module fault_signal_protocol_ctrl_bench;
  import fsp_pkg::*;
  typedef struct {string nm; logic [19:0] m; logic [19:0] v;} fsp_note_t;

  logic        clk_i = 0, rst_n_i = 0, por_n_i = 0, mode_we_i = 0;
  logic [1:0]  mode_i = 2'h0, rs = 2'h0, rp = 2'h0, fs, mo, arc;
  logic        tp_we = 0, fp_we = 0, mt_we = 0, rd_we = 0, fe = 0, fr = 0;
  logic [7:0]  tp = 8'h00, fp = 8'h00, per;
  logic [15:0] mt = 16'h0000, rd = 16'h0000;
  logic        fst, done, r0, r1, asy, both;
  logic [19:0] obs;
  logic [1:0]  codes [3] = '{2'h0, 2'h2, 2'h1};
  fsp_note_t   q[$];
  fsp_note_t   e;
  int          err_total = 0, compares = 0, i;
  int          seed = 32'hD500;

  assign obs = {both, per, arc, asy, r1, r0, done, fst, mo, fs};

  fsp_ctrl dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .por_n_i(por_n_i), .mode_we_i(mode_we_i),
    .mode_i(mode_i), .toggle_prescaler_we_i(tp_we), .toggle_prescaler_i(tp),
    .fault_state_prescaler_we_i(fp_we), .fault_state_prescaler_i(fp),
    .min_fault_state_time_we_i(mt_we), .min_fault_state_time_i(mt),
    .recovery_timer_duration_we_i(rd_we), .recovery_timer_duration_i(rd),
    .fault_enter_i(fe), .fault_release_i(fr), .recovery_start_i(rs), .recovery_stop_i(rp),
    .fault_signal_o(fs), .mode_o(mo), .fault_state_o(fst), .fault_state_timer_done_o(done),
    .recovery_timer0_running_o(r0), .recovery_timer1_running_o(r1),
    .alarm_sync_o(asy), .alarm_recovery_o(arc));

  fsp_mon mon (.clk_i(clk_i), .rst_n_i(rst_n_i), .pins_i(fs), .period_o(per), .both_o(both));

  always #12.5 clk_i = ~clk_i;

  task automatic check(input string nm, input logic [19:0] seen, input logic [19:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task end_of_test;
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // strobes are single-cycle pulses: one edge samples them, then they drop
  task step;
    @(posedge clk_i);
    #2;
    {mode_we_i, tp_we, fp_we, mt_we, rd_we, fe, fr} = 7'h00;
    rs = 2'h0;
    rp = 2'h0;
  endtask

  task cyc(input int n);
    repeat (n) step;
  endtask

  task note(input string nm, input logic [19:0] m, input logic [19:0] v);
    q.push_back('{nm, m, v});
    // a note spends one cycle, so no strobe is set again in the time step that step clears it
    @(posedge clk_i);
    #2;
  endtask

  task por_clear;
    por_n_i = 0;
    step;
    por_n_i = 1;
    note("power-on", 20'h00700, 20'h00000);
  endtask

  always @(negedge clk_i) begin
    if (q.size() > 0) begin
      e = q.pop_front();
      check(e.nm, obs & e.m, e.v);
    end
  end

  // bound on the whole run so a hang still reaches the verdict
  initial begin
    repeat (20000) @(posedge clk_i);
    err_total++;
    end_of_test;
  end

  initial begin
    repeat (10) @(posedge clk_i);
    #2;
    rst_n_i = 1;
    por_n_i = 1;
    step;
    note("reset", 20'h007FF, 20'h00001);
    for (i = 1; i < 3; i++) begin
      tp_we = 1;
      tp = 8'($random(seed) & 3) + 8'h02;
      step;
      mode_we_i = 1;
      mode_i = codes[i];
      step;
      note("mode", 20'h0000C, {16'h0000, codes[i], 2'h0});
      cyc(3 * tp + 12);
      note("toggle", 20'hFF800, {(i == 2), tp + 8'h01, 11'h000});
      if (i == 2) begin
        tp_we = 1;
        step;
        note("sync alarm", 20'h00100, 20'h00100);
      end
      mode_we_i = 1;
      mode_i = codes[0];
      step;
      cyc(2);
      note("bistable", 20'h0000C, 20'h00000);
    end
    rst_n_i = 0;
    step;
    rst_n_i = 1;
    note("warm reset", 20'h007FF, 20'h00101);
    por_clear;
    mode_we_i = 1;
    mode_i = 2'h3;
    step;
    tp_we = 1;
    step;
    cyc(2);
    note("reserved mode", 20'h0010F, 20'h0000D);
    mode_we_i = 1;
    mode_i = codes[0];
    step;
    fp_we = 1;
    fp = 8'h01;
    mt_we = 1;
    mt = 16'h0003;
    step;
    fe = 1;
    step;
    note("fault entry", 20'h0003F, 20'h00010);
    cyc(3);
    note("done low", 20'h00020, 20'h00000);
    mt_we = 1;
    step;
    note("sync alarm", 20'h00100, 20'h00100);
    cyc(10);
    note("done high", 20'h00020, 20'h00020);
    fr = 1;
    step;
    note("release", 20'h0001F, 20'h00001);
    por_clear;
    rd_we = 1;
    rd = 16'h0005;
    step;
    rs = 2'h1;
    step;
    note("timer0", 20'h000C0, 20'h00040);
    rs = 2'h2;
    step;
    note("timer1", 20'h000C0, 20'h000C0);
    rd_we = 1;
    step;
    note("recovery alarm", 20'h00600, 20'h00600);
    rp = 2'h2;
    step;
    note("stop timer1", 20'h00080, 20'h00000);
    cyc(20);
    note("expiry", 20'h000C0, 20'h00000);
    por_clear;
    end_of_test;
  end
endmodule
